// >>> shared/rea_pkg.sv
// Constants, types and register map of the reactive energy accumulator
`default_nettype none
package rea_pkg;
    // Register addresses
    localparam logic [7:0] ADDR_WAVE_SRC = 8'h0D;
    localparam logic [7:0] ADDR_NL_MODE = 8'h0E;
    localparam logic [7:0] ADDR_ACC_MODE = 8'h0F;
    localparam logic [7:0] ADDR_GAIN_OPT = 8'h1B;
    localparam logic [7:0] ADDR_IRQ_EN_LO = 8'hD9;
    localparam logic [7:0] ADDR_IRQ_EN_HI = 8'hDB;
    localparam logic [7:0] ADDR_IRQ_ST_LO = 8'hDC;
    localparam logic [7:0] ADDR_IRQ_ST_HI = 8'hDE;
    localparam logic [7:0] ADDR_GAIN_TRIM = 8'h20;
    localparam logic [7:0] ADDR_OFS_TRIM = 8'h21;
    localparam logic [7:0] ADDR_ENERGY = 8'h22;
    localparam logic [7:0] ADDR_ENERGY_RC = 8'h23;
    localparam logic [7:0] ADDR_DIVIDER = 8'h24;
    // Field positions
    localparam int NL_COMP_OFF_BIT = 7;
    localparam int NL_FIELD_LSB = 4;
    localparam int ACC_TAMPER_BIT = 2;
    localparam int ACC_ABS_BIT = 3;
    localparam int ACC_SIGN_DIR_BIT = 5;
    localparam int GAIN_SIGN_OPT_BIT = 7;
    localparam int ST_SIGN_BIT = 3;
    localparam int ST_NOLOAD_BIT = 5;
    localparam int ST_HALF_POS_BIT = 0;
    localparam int ST_HALF_NEG_BIT = 1;
    localparam int ST_OVF_BIT = 2;
    localparam int ST_UNF_BIT = 3;
    localparam int EN_HI_WAVE_BIT = 5;
    localparam int WAVE_RATE_LSB = 3;
    localparam logic [2:0] WAVE_SRC_REACTIVE = 3'h3;
    // Reset values
    localparam logic [7:0] RST_BYTE = 8'h00;
    localparam logic [11:0] RST_GAIN = 12'h000;
    localparam logic [15:0] RST_OFS = 16'h0000;
    localparam logic [48:0] RST_ACC = 49'h0;
    // Timing: one accumulation per this many master clock periods
    localparam int ACC_PERIOD_MCLK = 5;
    localparam int ACC_TICK_CYC = ACC_PERIOD_MCLK;
    localparam logic [2:0] ACC_TICK_LAST = 3'(ACC_TICK_CYC - 1);
    // Line frequency compensation
    localparam logic [6:0] FREQ_MIN_HZ = 7'h2D;
    localparam logic [6:0] FREQ_MAX_HZ = 7'h41;
    localparam logic [6:0] FREQ_NOM_HZ = 7'h32;
    localparam logic [13:0] COMP_UNITY = 14'h1000;
    // No-load thresholds in 1/256 sample LSB, fractions of full scale
    localparam longint FULL_SCALE = 64'h0000_0000_0040_0000;
    localparam logic [39:0] NL_THR_1 = 40'(FULL_SCALE * 256 * 15 / 100000);
    localparam logic [39:0] NL_THR_2 = 40'(FULL_SCALE * 256 * 75 / 1000000);
    localparam logic [39:0] NL_THR_3 = 40'(FULL_SCALE * 256 * 37 / 1000000);

    typedef struct packed {
        logic [7:0] addr;
        logic wr;
        logic rd;
        logic [23:0] wdata;
    } rea_reg_req_s;

    typedef struct packed {
        logic valid;
        logic signed [23:0] power;
    } rea_sample_s;

    typedef enum logic [2:0] {
        MODE_SIGNED = 3'b001,
        MODE_TAMPER = 3'b010,
        MODE_ABSOLUTE = 3'b100
    } rea_mode_e;
endpackage
`default_nettype wire

// >>> src/rea_core.sv
// Reactive power trim, sign and no-load detection, and energy accumulation
//
// Contract
// - Compensate line frequency 45..65 Hz; bit 7 of no-load mode disables.
// - Scale power by one plus signed 12-bit gain over 4096.
// - Add signed 16-bit offset trim into reactive power.
// - 256 offset LSBs equal one waveform sample LSB.
// - Phase shift is -90 degrees with integrator on, +90 off.
// - Angle 0..90 gives positive, -90..0 negative, either integrator state.
// - Sign change watched on filtered power or per pulse, by option bit.
// - Sign change sets flag; enabled flag holds interrupt until cleared.
// - Direction bit clear: flag on positive-to-negative transition.
// - Direction bit set: flag on negative-to-positive transition.
// - Below no-load threshold: no accumulation, no-load flag set.
// - Enabled no-load flag holds interrupt until software clears it.
// - No-load field: 00 off, 01/10/11 select 0.015/0.0075/0.0037 percent.
// - Signed 49-bit accumulator, upper 24 bits visible as energy view.
// - One sample accumulated every five master clock periods.
// - Both mode bits clear: signed accumulation.
// - Both mode bits set: absolute accumulation takes priority.
// - Anti-tamper: add when active power positive, subtract when negative.
// - Absolute mode accumulates magnitude of reactive power.
// - Divide by 8-bit divider; zero means divide by one.
// - Read-clear register returns view and clears upper 24 bits.
// - Waveform samples at four decimated rates when selected and enabled.
// - Energy view wraps across full scale in both directions.
// - Interrupts on half-full either sign, overflow and underflow.
`timescale 1ns/1ps
`default_nettype none
module rea_core
(
    input wire logic clock,
    input wire logic resetn,
    input wire rea_pkg::rea_reg_req_s reg_req,
    output logic [23:0] reg_rdata,
    input wire rea_pkg::rea_sample_s sample_in,
    input wire logic integrator_on,
    input wire logic active_power_negative,
    input wire logic frequency_output_pulse,
    input wire logic [6:0] line_freq_hz,
    output logic phase_shift_negative,
    output logic [23:0] wave_data,
    output logic wave_valid,
    output logic meas_irq_pending
);
    logic [7:0] wave_src_ff;
    logic [7:0] nl_mode_ff;
    logic [7:0] acc_mode_ff;
    logic [7:0] gain_opt_ff;
    logic [7:0] irq_en_lo_ff;
    logic [7:0] irq_en_hi_ff;
    logic [7:0] irq_st_lo_ff;
    logic [7:0] irq_st_hi_ff;
    logic [11:0] gain_trim_ff;
    logic [15:0] ofs_trim_ff;
    logic [7:0] divider_ff;
    logic signed [48:0] acc_ff;
    logic signed [39:0] q_ff;
    logic q_new_ff;
    logic signed [39:0] qdiv_ff;
    logic [2:0] tick_cnt_ff;
    logic [2:0] wave_cnt_ff;
    logic sign_prev_ff;
    logic sign_seen_ff;
    logic [23:0] nxt_rdata;
    logic [7:0] nxt_st_lo;
    logic [7:0] nxt_st_hi;
    logic signed [48:0] nxt_acc;

    function automatic logic [13:0] comp_factor(input logic [6:0] f, input logic off);
        logic [6:0] fc;
        logic [20:0] num;
        fc = f;
        num = 21'h0;
        if (fc < rea_pkg::FREQ_MIN_HZ)
            fc = rea_pkg::FREQ_MIN_HZ;
        else if (fc > rea_pkg::FREQ_MAX_HZ)
            fc = rea_pkg::FREQ_MAX_HZ;
        num = {14'h0, fc} * {7'h0, rea_pkg::COMP_UNITY};
        if (off)
            comp_factor = rea_pkg::COMP_UNITY;
        else
            comp_factor = 14'(num / {14'h0, rea_pkg::FREQ_NOM_HZ});
    endfunction

    function automatic logic signed [39:0] magnitude(input logic signed [39:0] v);
        magnitude = v[39] ? -v : v;
    endfunction

    // Register writes
    always_ff @(posedge clock or negedge resetn)
    begin
        if (!resetn)
        begin
            wave_src_ff <= rea_pkg::RST_BYTE;
            nl_mode_ff <= rea_pkg::RST_BYTE;
            acc_mode_ff <= rea_pkg::RST_BYTE;
            gain_opt_ff <= rea_pkg::RST_BYTE;
            irq_en_lo_ff <= rea_pkg::RST_BYTE;
            irq_en_hi_ff <= rea_pkg::RST_BYTE;
            gain_trim_ff <= rea_pkg::RST_GAIN;
            ofs_trim_ff <= rea_pkg::RST_OFS;
            divider_ff <= rea_pkg::RST_BYTE;
        end
        else if (reg_req.wr)
        begin
            if (reg_req.addr == rea_pkg::ADDR_WAVE_SRC)
                wave_src_ff <= reg_req.wdata[7:0];
            else if (reg_req.addr == rea_pkg::ADDR_NL_MODE)
                nl_mode_ff <= reg_req.wdata[7:0];
            else if (reg_req.addr == rea_pkg::ADDR_ACC_MODE)
                acc_mode_ff <= reg_req.wdata[7:0];
            else if (reg_req.addr == rea_pkg::ADDR_GAIN_OPT)
                gain_opt_ff <= reg_req.wdata[7:0];
            else if (reg_req.addr == rea_pkg::ADDR_IRQ_EN_LO)
                irq_en_lo_ff <= reg_req.wdata[7:0];
            else if (reg_req.addr == rea_pkg::ADDR_IRQ_EN_HI)
                irq_en_hi_ff <= reg_req.wdata[7:0];
            else if (reg_req.addr == rea_pkg::ADDR_GAIN_TRIM)
                gain_trim_ff <= reg_req.wdata[11:0];
            else if (reg_req.addr == rea_pkg::ADDR_OFS_TRIM)
                ofs_trim_ff <= reg_req.wdata[15:0];
            else if (reg_req.addr == rea_pkg::ADDR_DIVIDER)
                divider_ff <= reg_req.wdata[7:0];
        end
    end

    // Trim chain
    logic signed [24:0] p_in;
    logic signed [13:0] gain_f;
    logic signed [38:0] prod_g;
    logic signed [26:0] gained;
    logic signed [14:0] comp_f;
    logic signed [41:0] prod_c;
    logic signed [29:0] compd;
    logic signed [39:0] q_w;

    // Integrator on selects -90 shift, which inverts the product
    assign phase_shift_negative = integrator_on;
    assign p_in = integrator_on ? -{sample_in.power[23], sample_in.power}
                                : {sample_in.power[23], sample_in.power};
    assign gain_f = $signed(rea_pkg::COMP_UNITY) + {{2{gain_trim_ff[11]}}, gain_trim_ff};
    assign prod_g = p_in * gain_f;
    assign gained = prod_g[38:12];
    assign comp_f = $signed({1'b0,
        comp_factor(line_freq_hz, nl_mode_ff[rea_pkg::NL_COMP_OFF_BIT])});
    assign prod_c = gained * comp_f;
    assign compd = prod_c[41:12];
    // Offset sits eight bits below the sample LSB
    assign q_w = {{2{compd[29]}}, compd, 8'h00}
                 + {{24{ofs_trim_ff[15]}}, ofs_trim_ff};

    always_ff @(posedge clock or negedge resetn)
    begin
        if (!resetn)
        begin
            q_ff <= 40'sh0;
            q_new_ff <= 1'b0;
        end
        else
        begin
            q_new_ff <= sample_in.valid;
            if (sample_in.valid)
                q_ff <= q_w;
        end
    end

    // Divider stage, zero treated as one
    logic [7:0] div_eff;
    assign div_eff = (divider_ff == 8'h00) ? 8'h01 : divider_ff;

    always_ff @(posedge clock or negedge resetn)
    begin
        if (!resetn)
            qdiv_ff <= 40'sh0;
        else
            qdiv_ff <= q_ff / $signed({32'h0, div_eff});
    end

    // No-load detection
    logic [1:0] nl_field;
    logic [39:0] nl_thr;
    logic nl_active;
    assign nl_field = nl_mode_ff[rea_pkg::NL_FIELD_LSB +: 2];
    always_comb
    begin
        case (nl_field)
            2'h1: nl_thr = rea_pkg::NL_THR_1;
            2'h2: nl_thr = rea_pkg::NL_THR_2;
            2'h3: nl_thr = rea_pkg::NL_THR_3;
            default: nl_thr = 40'h0;
        endcase
    end
    assign nl_active = (nl_field != 2'h0) && ($unsigned(magnitude(q_ff)) < nl_thr);

    // Accumulation mode, absolute has priority
    rea_pkg::rea_mode_e mode;
    always_comb
    begin
        if (acc_mode_ff[rea_pkg::ACC_ABS_BIT])
            mode = rea_pkg::MODE_ABSOLUTE;
        else if (acc_mode_ff[rea_pkg::ACC_TAMPER_BIT])
            mode = rea_pkg::MODE_TAMPER;
        else
            mode = rea_pkg::MODE_SIGNED;
    end

    logic signed [39:0] inc;
    always_comb
    begin
        case (mode)
            rea_pkg::MODE_TAMPER: inc = active_power_negative ? -qdiv_ff : qdiv_ff;
            rea_pkg::MODE_ABSOLUTE: inc = magnitude(qdiv_ff);
            default: inc = qdiv_ff;
        endcase
    end

    // Five-period accumulation tick
    logic tick;
    assign tick = (tick_cnt_ff == rea_pkg::ACC_TICK_LAST);
    always_ff @(posedge clock or negedge resetn)
    begin
        if (!resetn)
            tick_cnt_ff <= 3'h0;
        else if (tick)
            tick_cnt_ff <= 3'h0;
        else
            tick_cnt_ff <= tick_cnt_ff + 3'h1;
    end

    logic rc_read;
    logic signed [48:0] acc_base;
    assign rc_read = reg_req.rd && (reg_req.addr == rea_pkg::ADDR_ENERGY_RC);
    assign acc_base = rc_read ? {24'h0, acc_ff[24:0]} : acc_ff;
    always_comb
    begin
        if (tick && !nl_active)
            nxt_acc = acc_base + {{9{inc[39]}}, inc};
        else
            nxt_acc = acc_base;
    end

    always_ff @(posedge clock or negedge resetn)
    begin
        if (!resetn)
            acc_ff <= rea_pkg::RST_ACC;
        else
            acc_ff <= nxt_acc;
    end

    // Energy range events from the top two bits
    logic [1:0] top_old;
    logic [1:0] top_new;
    logic acc_step;
    assign top_old = acc_base[48:47];
    assign top_new = nxt_acc[48:47];
    assign acc_step = tick && !nl_active;

    // Sign change detection
    logic sign_opt_pulse;
    logic sign_sample;
    logic sign_now;
    logic sign_event;
    assign sign_opt_pulse = gain_opt_ff[rea_pkg::GAIN_SIGN_OPT_BIT];
    assign sign_sample = sign_opt_pulse ? frequency_output_pulse : q_new_ff;
    assign sign_now = q_ff[39];
    always_comb
    begin
        sign_event = 1'b0;
        if (sign_sample && sign_seen_ff && (sign_now != sign_prev_ff))
        begin
            if (acc_mode_ff[rea_pkg::ACC_SIGN_DIR_BIT])
                sign_event = !sign_now;
            else
                sign_event = sign_now;
        end
    end

    always_ff @(posedge clock or negedge resetn)
    begin
        if (!resetn)
        begin
            sign_prev_ff <= 1'b0;
            sign_seen_ff <= 1'b0;
        end
        else if (sign_sample)
        begin
            sign_prev_ff <= sign_now;
            sign_seen_ff <= 1'b1;
        end
    end

    // Status flags, write one to clear, a new event wins over the clear
    logic [7:0] clr_lo;
    logic [7:0] clr_hi;
    always_comb
    begin
        clr_lo = 8'h00;
        clr_hi = 8'h00;
        if (reg_req.wr && (reg_req.addr == rea_pkg::ADDR_IRQ_ST_LO))
            clr_lo = reg_req.wdata[7:0];
        if (reg_req.wr && (reg_req.addr == rea_pkg::ADDR_IRQ_ST_HI))
            clr_hi = reg_req.wdata[7:0];
        nxt_st_lo = irq_st_lo_ff & ~clr_lo;
        nxt_st_hi = irq_st_hi_ff & ~clr_hi;
        if (sign_event)
            nxt_st_lo[rea_pkg::ST_SIGN_BIT] = 1'b1;
        if (nl_active)
            nxt_st_lo[rea_pkg::ST_NOLOAD_BIT] = 1'b1;
        if (acc_step && top_old == 2'b00 && top_new == 2'b01)
            nxt_st_hi[rea_pkg::ST_HALF_POS_BIT] = 1'b1;
        if (acc_step && top_old == 2'b11 && top_new == 2'b10)
            nxt_st_hi[rea_pkg::ST_HALF_NEG_BIT] = 1'b1;
        if (acc_step && top_old == 2'b01 && top_new == 2'b10)
            nxt_st_hi[rea_pkg::ST_OVF_BIT] = 1'b1;
        if (acc_step && top_old == 2'b10 && top_new == 2'b01)
            nxt_st_hi[rea_pkg::ST_UNF_BIT] = 1'b1;
    end

    always_ff @(posedge clock or negedge resetn)
    begin
        if (!resetn)
        begin
            irq_st_lo_ff <= rea_pkg::RST_BYTE;
            irq_st_hi_ff <= rea_pkg::RST_BYTE;
        end
        else
        begin
            irq_st_lo_ff <= nxt_st_lo;
            irq_st_hi_ff <= nxt_st_hi;
        end
    end

    // Pending while any enabled flag stands
    assign meas_irq_pending = |(irq_st_lo_ff & irq_en_lo_ff)
                              | |(irq_st_hi_ff & irq_en_hi_ff);

    // Waveform output, decimated by 1, 2, 4 or 8
    logic [1:0] wave_rate;
    logic [2:0] wave_mask;
    logic wave_on;
    assign wave_rate = wave_src_ff[rea_pkg::WAVE_RATE_LSB +: 2];
    assign wave_on = (wave_src_ff[2:0] == rea_pkg::WAVE_SRC_REACTIVE)
                     && irq_en_hi_ff[rea_pkg::EN_HI_WAVE_BIT];
    always_comb
    begin
        case (wave_rate)
            2'h1: wave_mask = 3'h1;
            2'h2: wave_mask = 3'h3;
            2'h3: wave_mask = 3'h7;
            default: wave_mask = 3'h0;
        endcase
    end

    always_ff @(posedge clock or negedge resetn)
    begin
        if (!resetn)
        begin
            wave_cnt_ff <= 3'h0;
            wave_valid <= 1'b0;
            wave_data <= 24'h0;
        end
        else
        begin
            wave_valid <= 1'b0;
            if (q_new_ff)
            begin
                wave_cnt_ff <= wave_cnt_ff + 3'h1;
                if (wave_on && ((wave_cnt_ff & wave_mask) == 3'h0))
                begin
                    wave_valid <= 1'b1;
                    wave_data <= q_ff[31:8];
                end
            end
        end
    end

    // Read port
    always_comb
    begin
        nxt_rdata = 24'h0;
        if (reg_req.addr == rea_pkg::ADDR_WAVE_SRC)
            nxt_rdata = {16'h0, wave_src_ff};
        else if (reg_req.addr == rea_pkg::ADDR_NL_MODE)
            nxt_rdata = {16'h0, nl_mode_ff};
        else if (reg_req.addr == rea_pkg::ADDR_ACC_MODE)
            nxt_rdata = {16'h0, acc_mode_ff};
        else if (reg_req.addr == rea_pkg::ADDR_GAIN_OPT)
            nxt_rdata = {16'h0, gain_opt_ff};
        else if (reg_req.addr == rea_pkg::ADDR_IRQ_EN_LO)
            nxt_rdata = {16'h0, irq_en_lo_ff};
        else if (reg_req.addr == rea_pkg::ADDR_IRQ_EN_HI)
            nxt_rdata = {16'h0, irq_en_hi_ff};
        else if (reg_req.addr == rea_pkg::ADDR_IRQ_ST_LO)
            nxt_rdata = {16'h0, irq_st_lo_ff};
        else if (reg_req.addr == rea_pkg::ADDR_IRQ_ST_HI)
            nxt_rdata = {16'h0, irq_st_hi_ff};
        else if (reg_req.addr == rea_pkg::ADDR_GAIN_TRIM)
            nxt_rdata = {12'h0, gain_trim_ff};
        else if (reg_req.addr == rea_pkg::ADDR_OFS_TRIM)
            nxt_rdata = {8'h0, ofs_trim_ff};
        else if (reg_req.addr == rea_pkg::ADDR_DIVIDER)
            nxt_rdata = {16'h0, divider_ff};
        else if (reg_req.addr == rea_pkg::ADDR_ENERGY || reg_req.addr == rea_pkg::ADDR_ENERGY_RC)
            nxt_rdata = acc_ff[48:25];
    end

    always_ff @(posedge clock or negedge resetn)
    begin
        if (!resetn)
            reg_rdata <= 24'h0;
        else if (reg_req.rd)
            reg_rdata <= nxt_rdata;
    end

    // Checks
    default clocking cb @(posedge clock); endclocking
    default disable iff (!resetn);

    a_tick_spacing: assert property (tick |=> !tick [*4] ##1 tick)
        else $error("accumulation tick spacing wrong");
    a_noload_hold: assert property (tick && nl_active && !rc_read
        |=> acc_ff == $past(acc_ff))
        else $error("accumulated during no-load");
    a_noload_flag: assert property (nl_active |=> irq_st_lo_ff[rea_pkg::ST_NOLOAD_BIT])
        else $error("no-load flag not set");
    a_rc_clears: assert property (rc_read && !tick |=> acc_ff[48:25] == 24'h0)
        else $error("read-clear left upper bits");
    a_rc_data: assert property (rc_read |=> reg_rdata == $past(acc_ff[48:25]))
        else $error("read-clear returned wrong view");
    a_irq_hold: assert property (irq_st_lo_ff[rea_pkg::ST_SIGN_BIT]
        && irq_en_lo_ff[rea_pkg::ST_SIGN_BIT] |-> meas_irq_pending)
        else $error("sign interrupt not pending");
    a_noload_irq: assert property (irq_st_lo_ff[rea_pkg::ST_NOLOAD_BIT]
        && irq_en_lo_ff[rea_pkg::ST_NOLOAD_BIT] |-> meas_irq_pending)
        else $error("no-load interrupt not pending");
    a_div_one: assert property (divider_ff == 8'h00 ##1 divider_ff == 8'h00
        |-> qdiv_ff == $past(q_ff))
        else $error("zero divider did not pass value");
    a_abs_positive: assert property (mode == rea_pkg::MODE_ABSOLUTE |-> !inc[39])
        else $error("absolute mode increment negative");
    a_sign_flag: assert property (sign_event |=> irq_st_lo_ff[rea_pkg::ST_SIGN_BIT])
        else $error("sign flag not set");
    a_wave_gate: assert property (wave_valid |-> $past(wave_on) && $past(q_new_ff))
        else $error("waveform sample without selection");

    c_sign_event: cover property (sign_event);
    c_overflow: cover property (acc_step && top_old == 2'b01 && top_new == 2'b10);
    c_rc_read: cover property (rc_read && tick);
    c_noload: cover property (nl_active ##1 !nl_active);
endmodule
`default_nettype wire

// >>> test/rea_cpu_model.sv
// Processor-side register access model for the reactive energy accumulator
`timescale 1ns/1ps
`default_nettype none
module rea_cpu_model
(
    input wire logic clock,
    output var rea_pkg::rea_reg_req_s reg_req,
    input wire logic [23:0] reg_rdata
);
    initial reg_req = '0;
    // Write strobe held for exactly one rising edge
    task automatic wr(input logic [7:0] a, input logic [23:0] d);
        @(negedge clock);
        reg_req = '{addr: a, wr: 1'b1, rd: 1'b0, wdata: d};
        @(negedge clock);
        reg_req.wr = 1'b0;
        reg_req.wdata = ~d;
    endtask
    // Read data is registered, so it is taken one edge after the strobe
    task automatic rd(input logic [7:0] a, output logic [23:0] d);
        @(negedge clock);
        reg_req = '{addr: a, wr: 1'b0, rd: 1'b1, wdata: 24'h000000};
        @(negedge clock);
        reg_req.rd = 1'b0;
        d = reg_rdata;
    endtask
endmodule
`default_nettype wire

// >>> test/reactive_energy_accumulator_tb.sv
// Self-checking testbench for the reactive energy accumulator
`timescale 1ns/1ps
`default_nettype none
module reactive_energy_accumulator_tb;
    logic clock = 1'b0;
    logic resetn = 1'b0;
    rea_pkg::rea_reg_req_s reg_req;
    rea_pkg::rea_sample_s smp = '0;
    logic [23:0] reg_rdata, wave_data, v, p;
    logic integrator_on = 1'b0;
    logic apn = 1'b0;
    logic fpulse = 1'b0;
    logic [6:0] line_freq = 7'h32;
    logic phase_neg, wave_valid, irq;
    int n_fail = 0;
    int total_checks = 0;
    int cycles = 0;
    logic [7:0] addrs[8] = '{8'h0D, 8'h0E, 8'h0F, 8'h1B, 8'hD9, 8'hDB, 8'hDC, 8'h55};
    logic [7:0] mode[6] = '{8'h00, 8'h00, 8'h04, 8'h04, 8'h08, 8'h0C};
    logic apn_t[6] = '{1'b0, 1'b0, 1'b1, 1'b0, 1'b0, 1'b0};
    logic [23:0] pw[6] = '{24'h300000, 24'hD00000, 24'h300000, 24'hD00000, 24'hD00000, 24'hD00000};

    rea_core uut (.clock(clock), .resetn(resetn), .reg_req(reg_req), .reg_rdata(reg_rdata),
        .sample_in(smp), .integrator_on(integrator_on), .active_power_negative(apn),
        .frequency_output_pulse(fpulse), .line_freq_hz(line_freq),
        .phase_shift_negative(phase_neg), .wave_data(wave_data), .wave_valid(wave_valid),
        .meas_irq_pending(irq));
    rea_cpu_model cpu (.clock(clock), .reg_req(reg_req), .reg_rdata(reg_rdata));

    initial forever #25 clock = ~clock;

    always @(posedge clock)
    begin
        cycles <= cycles + 1;
        if (cycles == 20000)
        begin
            n_fail++;
            summarize();
        end
    end

    task automatic summarize();
        $display("checks %0d mismatches %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    task automatic chk(input string name, input logic [23:0] exp, input logic [23:0] got);
        total_checks++;
        if (got !== exp)
        begin
            n_fail++;
            $display("wrong value %s expected %h seen %h", name, exp, got);
        end
    endtask

    // Expected energy sign: absolute wins, anti-tamper flips on negative active power
    function automatic logic [23:0] exp_neg(input int i);
        if (mode[i][rea_pkg::ACC_ABS_BIT])
            return 24'h000000;
        if (mode[i][rea_pkg::ACC_TAMPER_BIT])
            return {23'h0, pw[i][23] ^ apn_t[i]};
        return {23'h0, pw[i][23]};
    endfunction

    // One sample strobe, then wait for the waveform pulse under a bound
    task automatic send(input logic [23:0] pv, input logic [23:0] exp, input logic chkw);
        int k;
        @(negedge clock);
        smp = '{valid: 1'b1, power: pv};
        @(negedge clock);
        smp.valid = 1'b0;
        k = 0;
        while (wave_valid !== 1'b1 && k < 8)
        begin
            @(negedge clock);
            k++;
        end
        if (chkw)
        begin
            chk("wave_valid", 24'h000001, {23'h0, wave_valid});
            chk("wave_data", exp, wave_data);
        end
    endtask

    initial
    begin
        void'($urandom(32'hee0439fe));
        repeat (3) @(negedge clock);
        resetn = 1'b1;
        foreach (addrs[i])
        begin
            cpu.rd(addrs[i], v);
            chk("reset value", 24'h000000, v);
        end
        for (int i = 0; i < 6; i++)
        begin
            p = {16'h0000, 8'($urandom)};
            cpu.wr(addrs[i], p);
            cpu.rd(addrs[i], v);
            chk("readback", p, v);
            cpu.wr(addrs[i], 24'h000000);
        end
        integrator_on = 1'b1;
        #1 chk("phase", 24'h000001, {23'h0, phase_neg});
        integrator_on = 1'b0;
        cpu.wr(rea_pkg::ADDR_WAVE_SRC, 24'h000003);
        cpu.wr(rea_pkg::ADDR_IRQ_EN_HI, 24'h000020);
        for (int i = 0; i < 6; i++)
        begin
            p = 24'($urandom);
            send(p, p, 1'b1);
        end
        cpu.wr(rea_pkg::ADDR_GAIN_TRIM, 24'h000800);
        send(24'h001000, 24'h000800, 1'b1);
        cpu.wr(rea_pkg::ADDR_NL_MODE, 24'h000080);
        line_freq = 7'h41;
        send(24'h001000, 24'h000800, 1'b1);
        cpu.wr(rea_pkg::ADDR_NL_MODE, 24'h000000);
        send(24'h001000, 24'h000A66, 1'b1);
        line_freq = 7'h32;
        cpu.wr(rea_pkg::ADDR_GAIN_TRIM, 24'h000000);
        cpu.wr(rea_pkg::ADDR_OFS_TRIM, 24'h000100);
        send(24'h001000, 24'h001001, 1'b1);
        cpu.wr(rea_pkg::ADDR_OFS_TRIM, 24'h000000);
        integrator_on = 1'b1;
        send(24'h001000, 24'hFFF000, 1'b1);
        integrator_on = 1'b0;
        // Sign change, default direction, then reversed direction
        cpu.wr(rea_pkg::ADDR_IRQ_EN_LO, 24'h000008);
        cpu.wr(rea_pkg::ADDR_IRQ_ST_LO, 24'h000008);
        send(24'h001000, 24'h0, 1'b0);
        cpu.rd(rea_pkg::ADDR_IRQ_ST_LO, v);
        chk("sign flag rise", 24'h000000, {23'h0, v[3]});
        send(24'hFFF000, 24'h0, 1'b0);
        cpu.rd(rea_pkg::ADDR_IRQ_ST_LO, v);
        chk("sign flag", 24'h000001, {23'h0, v[3]});
        chk("irq pending", 24'h000001, {23'h0, irq});
        cpu.wr(rea_pkg::ADDR_ACC_MODE, 24'h000020);
        cpu.wr(rea_pkg::ADDR_IRQ_ST_LO, 24'h000008);
        chk("irq cleared", 24'h000000, {23'h0, irq});
        send(24'h001000, 24'h0, 1'b0);
        cpu.rd(rea_pkg::ADDR_IRQ_ST_LO, v);
        chk("sign flag up", 24'h000001, {23'h0, v[3]});
        cpu.wr(rea_pkg::ADDR_IRQ_ST_LO, 24'h000008);
        send(24'hFFF000, 24'h0, 1'b0);
        cpu.rd(rea_pkg::ADDR_IRQ_ST_LO, v);
        chk("sign flag down", 24'h000000, {23'h0, v[3]});
        // Per-pulse option: sign sampled only on a pulse
        cpu.wr(rea_pkg::ADDR_GAIN_OPT, 24'h000080);
        send(24'h001000, 24'h0, 1'b0);
        cpu.rd(rea_pkg::ADDR_IRQ_ST_LO, v);
        chk("no pulse flag", 24'h000000, {23'h0, v[3]});
        fpulse = 1'b1;
        @(negedge clock);
        fpulse = 1'b0;
        cpu.rd(rea_pkg::ADDR_IRQ_ST_LO, v);
        chk("pulse flag", 24'h000001, {23'h0, v[3]});
        cpu.wr(rea_pkg::ADDR_GAIN_OPT, 24'h000000);
        cpu.wr(rea_pkg::ADDR_IRQ_EN_LO, 24'h000000);
        // Ten accumulation periods per mode after a read-clear
        for (int i = 0; i < 6; i++)
        begin
            cpu.wr(rea_pkg::ADDR_ACC_MODE, {16'h0, mode[i]});
            apn = apn_t[i];
            send(pw[i], 24'h0, 1'b0);
            cpu.rd(rea_pkg::ADDR_ENERGY_RC, v);
            repeat (50) @(negedge clock);
            cpu.rd(rea_pkg::ADDR_ENERGY, v);
            chk("energy sign", exp_neg(i), {23'h0, v[23]});
        end
        cpu.rd(rea_pkg::ADDR_ENERGY_RC, v);
        cpu.rd(rea_pkg::ADDR_ENERGY, v);
        chk("cleared view", 24'h000000, {8'h00, v[23:8]});
        // No-load with smallest field code
        apn = 1'b0;
        cpu.wr(rea_pkg::ADDR_ACC_MODE, 24'h000000);
        cpu.wr(rea_pkg::ADDR_NL_MODE, 24'h000010);
        cpu.wr(rea_pkg::ADDR_IRQ_EN_LO, 24'h000020);
        send(24'h000010, 24'h0, 1'b0);
        cpu.rd(rea_pkg::ADDR_ENERGY_RC, v);
        repeat (50) @(negedge clock);
        cpu.rd(rea_pkg::ADDR_ENERGY, v);
        chk("no-load energy", 24'h000000, v);
        cpu.rd(rea_pkg::ADDR_IRQ_ST_LO, v);
        chk("no-load flag", 24'h000001, {23'h0, v[5]});
        chk("no-load irq", 24'h000001, {23'h0, irq});
        cpu.wr(rea_pkg::ADDR_NL_MODE, 24'h000000);
        cpu.wr(rea_pkg::ADDR_IRQ_ST_LO, 24'h000020);
        chk("no-load irq off", 24'h000000, {23'h0, irq});
        // Sample between the smallest and largest thresholds
        send(24'h000100, 24'h0, 1'b0);
        cpu.wr(rea_pkg::ADDR_NL_MODE, 24'h000030);
        cpu.rd(rea_pkg::ADDR_IRQ_ST_LO, v);
        chk("no-load code 3", 24'h000000, {23'h0, v[5]});
        cpu.wr(rea_pkg::ADDR_NL_MODE, 24'h000010);
        cpu.rd(rea_pkg::ADDR_IRQ_ST_LO, v);
        chk("no-load code 1", 24'h000001, {23'h0, v[5]});
        summarize();
    end
endmodule
`default_nettype wire
